// ==== verilog/smmc_regs.vh ====
// Constants for the safe monitor mode controller.
// Assumes a 100 MHz system clock; included by the controller only.
`ifndef SMMC_REGS_VH
`define SMMC_REGS_VH
// Mode state codes
`define SMMC_MODE_CMD        2'h0
`define SMMC_MODE_SLEEP      2'h1
`define SMMC_MODE_DIAG       2'h2
`define SMMC_MODE_SAFE       2'h3
// Pin function codes (3 bits)
`define SMMC_CFG_INPUT       3'h0
`define SMMC_CFG_SM_HI       3'h6
`define SMMC_CFG_SM_ONESHOT  3'h7
// Timing
`define SMMC_CLK_MHZ         100
`define SMMC_ONESHOT_MS      100
`define SMMC_ONESHOT_CYCLES  (`SMMC_ONESHOT_MS * 1000 * `SMMC_CLK_MHZ)
// Pin mask reset value: all masked
`define SMMC_PIN_MASK_RST    4'hF
`endif

// ==== verilog/smmc_controller.v ====
// Operating-mode supervisor: commanded, sleep and safe-monitoring modes.
// Assumes synchronous inputs; watchdog checks, poll results and write
// attempts arrive as one-cycle pulses from neighbouring logic.
//
// Summary of operation
// - Power-up in commanded mode, watchdog off
// - Master enters safe mode on watchdog debounce
// - Timeout from open, closed, divider, unit
// - Exit only by valid key or soft reset
// - Sleep enable enters sleep, starts timer
// - Leave sleep on clear, timer, debounce, reset
// - Sleep suppresses keep-alive and scheduled polls
// - Sleep polls at sleep scan delay interval
// - Sleep poll error sets alert, exits sleep
// - Sleep discards config writes, flags error
// - Each poll status bit individually maskable
// - Safe mode triggers configuration memory load
// - Slave enters safe mode only on pin three
// - Safe entry sets alert; interrupt if enabled
// - Diagnostic window asserts all pin drives
// - Masked pins idle inactive in the window, readback shows drive
// - Code 110 drives active high, idles low
// - Refresh in diagnostic returns to commanded
// - No refresh by delay end asserts pin four
// - Communication fault in safe mode asserts pin three
// - All pins default to inputs
// - One-shot low output pulses low 100ms
// - Interrupt low when any enabled flag set
`timescale 1ns/1ns
`include "smmc_regs.vh"
module smmc_controller #(
   parameter DBNC_W   = 4,                   // Debounce count width
   parameter TIME_W   = 24,                  // Timer width
   parameter ONESHOT  = `SMMC_ONESHOT_CYCLES // One-shot length, cycles
) (
   // Clock and reset
   input  wire              sys_clk,
   input  wire              reset,
   input  wire              software_power_on_reset,
   // Watchdog configuration and events
   input  wire              watchdog_enable,
   input  wire [DBNC_W-1:0] watchdog_fail_debounce,
   input  wire [7:0]        watchdog_open_window,
   input  wire [7:0]        watchdog_closed_window,
   input  wire [3:0]        watchdog_clock_divider,
   input  wire [7:0]        watchdog_time_unit,
   input  wire              watchdog_key_valid,
   input  wire              watchdog_key_invalid,
   input  wire [1:0]        master_slave_select,
   // Sleep control
   input  wire              sleep_enable,
   input  wire [TIME_W-1:0] sleep_notify_timer,
   input  wire              sleep_alert_poll_enable,
   input  wire [TIME_W-1:0] sleep_scan_delay,
   input  wire [DBNC_W-1:0] alert_poll_debounce,
   input  wire              sleep_error_alert_enable,
   // Poll results
   input  wire              poll_result_valid,
   input  wire [15:0]       alert_poll_packet,
   input  wire [15:0]       poll_status_mask,
   input  wire              comm_fault,
   // Write attempts and alert clearing
   input  wire              cfg_write_attempt,
   input  wire              spi_error_enable,
   input  wire              spi_error_clear,
   input  wire              safe_monitor_alert_enable,
   input  wire              safe_monitor_alert_clear,
   input  wire              sleep_error_clear,
   // Safe mode configuration
   input  wire [TIME_W-1:0] gpio_recovery_delay,
   input  wire [3:0]        safe_monitor_pin_mask,
   input  wire              mask_write,
   input  wire [11:0]       pin_function_config,
   input  wire              recovery_pin_three,
   // Outputs
   output reg  [1:0]        mode_reg,
   output reg               cfg_write_accept_reg,
   output reg               keep_alive_enable_reg,
   output reg               poll_request_reg,
   output reg               load_config_reg,
   output reg               safe_monitor_alert_status_reg,
   output reg               sleep_error_alert_status_reg,
   output reg               spi_error_status_reg,
   output reg               alert_n_out_reg,
   output reg               alert_n_oe_reg,
   output reg  [3:0]        pin_drive_readback_reg,
   output reg  [3:0]        pin_out_reg,
   output reg  [3:0]        pin_oe_n_reg,
   output reg  [TIME_W-1:0] watchdog_timeout_reg
);
   // Internal state
   reg [DBNC_W-1:0] wd_fail_reg;        // Consecutive invalid responses
   reg [DBNC_W-1:0] poll_fail_reg;      // Consecutive sleep poll faults
   reg [TIME_W-1:0] timer_reg;          // Sleep notify / diagnostic timer
   reg [TIME_W-1:0] scan_reg;           // Sleep scan interval counter
   reg [3:0]        drive_reg;          // Internal controller drive
   reg [3:0]        pin_mask_reg;       // Per-pin safe monitor mask
   reg              diag_done_reg;      // Past the diagnostic window
   reg [31:0]       shot_reg [0:3];     // One-shot counters per pin
   reg              sleep_en_d_reg;     // Edge detect of sleep enable
   reg              diag_drv_reg;       // Drive still comes from window
   reg [3:0]        act_d_reg;          // Pin assertion, one cycle late
   wire [3:0]       pin_act;            // Drive after the window mask
   wire [31:0]      wd_sum;             // Sum of both windows
   wire [31:0]      wd_span;            // Scaled and shifted timeout
   wire [1:0]       mode_next;
   wire             soft_rst = reset | software_power_on_reset;
   wire             is_master = master_slave_select[1];
   wire             poll_fault = |(alert_poll_packet & ~poll_status_mask);
   integer          i;

   // Mask follows the drive's source, not the mode, so the drive left
   // over from the window cannot leak onto a pin for one cycle
   assign pin_act = drive_reg & ~(pin_mask_reg & {4{diag_drv_reg}});

   // Timeout arithmetic in 32 bits; TIME_W must not exceed 32
   assign wd_sum  = {24'h00_0000, watchdog_open_window}
                    + {24'h00_0000, watchdog_closed_window};
   assign wd_span = (wd_sum * {24'h00_0000, watchdog_time_unit})
                    << watchdog_clock_divider;

   // Pin function field of pin k
   function [2:0] pin_cfg;
      input [11:0] cfg;
      input integer k;
      begin
         pin_cfg = cfg[k*3 +: 3];
      end
   endfunction

   // Timeout grows with both windows, scaled by divider and time unit
   always @(posedge sys_clk) begin
      watchdog_timeout_reg <= wd_span[TIME_W-1:0];
   end

   // Mode sequencing
   reg [1:0] mode_n;
   always @* begin
      mode_n = mode_reg;
      case (mode_reg)
         `SMMC_MODE_CMD: begin
            if (sleep_enable && !sleep_en_d_reg)
               mode_n = `SMMC_MODE_SLEEP;
            else if (is_master && watchdog_enable && watchdog_key_invalid
                     && wd_fail_reg >= watchdog_fail_debounce)
               mode_n = `SMMC_MODE_DIAG;
            else if (!is_master && recovery_pin_three)
               mode_n = `SMMC_MODE_DIAG;
         end
         `SMMC_MODE_SLEEP: begin
            if (!sleep_enable || timer_reg == {TIME_W{1'b0}})
               mode_n = `SMMC_MODE_CMD;
            else if (poll_result_valid && poll_fault
                     && poll_fail_reg >= alert_poll_debounce)
               mode_n = `SMMC_MODE_CMD;
         end
         `SMMC_MODE_DIAG: begin
            if (watchdog_key_valid)
               mode_n = `SMMC_MODE_CMD;
            else if (timer_reg == {TIME_W{1'b0}})
               mode_n = `SMMC_MODE_SAFE;
         end
         `SMMC_MODE_SAFE: begin
            if (watchdog_key_valid)
               mode_n = `SMMC_MODE_CMD;
         end
         default: mode_n = `SMMC_MODE_CMD;
      endcase
   end
   assign mode_next = mode_n;

   // Mode, counters and status flags
   always @(posedge sys_clk) begin
      if (soft_rst) begin
         mode_reg                      <= `SMMC_MODE_CMD;
         wd_fail_reg                   <= {DBNC_W{1'b0}};
         poll_fail_reg                 <= {DBNC_W{1'b0}};
         timer_reg                     <= {TIME_W{1'b0}};
         scan_reg                      <= {TIME_W{1'b0}};
         sleep_en_d_reg                <= 1'b0;
         diag_done_reg                 <= 1'b0;
         load_config_reg               <= 1'b0;
         poll_request_reg              <= 1'b0;
         safe_monitor_alert_status_reg <= 1'b0;
         sleep_error_alert_status_reg  <= 1'b0;
         spi_error_status_reg          <= 1'b0;
         cfg_write_accept_reg          <= 1'b0;
         keep_alive_enable_reg         <= 1'b0;
         pin_mask_reg                  <= `SMMC_PIN_MASK_RST;
      end else begin
         mode_reg       <= mode_next;
         sleep_en_d_reg <= sleep_enable;
         if (mask_write)
            pin_mask_reg <= safe_monitor_pin_mask;
         // Watchdog counts only in commanded mode; sleep disables it
         if (mode_reg != `SMMC_MODE_CMD || watchdog_key_valid)
            wd_fail_reg <= {DBNC_W{1'b0}};
         else if (watchdog_enable && watchdog_key_invalid
                  && wd_fail_reg != {DBNC_W{1'b1}})
            wd_fail_reg <= wd_fail_reg + 1'b1;
         // Timer loads on entry to sleep or diagnostic, else counts down
         if (mode_next == `SMMC_MODE_SLEEP && mode_reg != mode_next)
            timer_reg <= sleep_notify_timer;
         else if (mode_next == `SMMC_MODE_DIAG && mode_reg != mode_next)
            timer_reg <= gpio_recovery_delay;
         else if (timer_reg != {TIME_W{1'b0}})
            timer_reg <= timer_reg - 1'b1;
         // Sleep polling at the scan interval
         poll_request_reg <= 1'b0;
         if (mode_reg == `SMMC_MODE_SLEEP && sleep_alert_poll_enable) begin
            if (scan_reg == {TIME_W{1'b0}}) begin
               scan_reg         <= sleep_scan_delay;
               poll_request_reg <= 1'b1;
            end else
               scan_reg <= scan_reg - 1'b1;
         end else
            scan_reg <= sleep_scan_delay;
         if (mode_reg != `SMMC_MODE_SLEEP)
            poll_fail_reg <= {DBNC_W{1'b0}};
         else if (poll_result_valid)
            poll_fail_reg <= poll_fault ? poll_fail_reg + 1'b1
                                        : {DBNC_W{1'b0}};
         keep_alive_enable_reg <= (mode_next == `SMMC_MODE_CMD);
         cfg_write_accept_reg  <= cfg_write_attempt
                                  && mode_reg != `SMMC_MODE_SLEEP;
         diag_done_reg   <= (mode_next == `SMMC_MODE_SAFE);
         load_config_reg <= (mode_next == `SMMC_MODE_SAFE)
                            && !diag_done_reg;
         // Flags: a set in the same cycle beats a clear
         if (mode_next == `SMMC_MODE_DIAG || mode_reg == `SMMC_MODE_DIAG
             || mode_reg == `SMMC_MODE_SAFE)
            safe_monitor_alert_status_reg <= 1'b1;
         else if (safe_monitor_alert_clear)
            safe_monitor_alert_status_reg <= 1'b0;
         if (mode_reg == `SMMC_MODE_SLEEP && poll_result_valid
             && poll_fault && poll_fail_reg >= alert_poll_debounce)
            sleep_error_alert_status_reg <= 1'b1;
         else if (sleep_error_clear)
            sleep_error_alert_status_reg <= 1'b0;
         if (cfg_write_attempt && mode_reg == `SMMC_MODE_SLEEP)
            spi_error_status_reg <= 1'b1;
         else if (spi_error_clear)
            spi_error_status_reg <= 1'b0;
      end
   end

   // Interrupt pin: open drain, enable low pulls the line low
   always @(posedge sys_clk) begin
      alert_n_out_reg <= 1'b0;
      if (soft_rst)
         alert_n_oe_reg <= 1'b1;
      else
         alert_n_oe_reg <= !((safe_monitor_alert_status_reg
                              && safe_monitor_alert_enable)
                             || (sleep_error_alert_status_reg
                                 && sleep_error_alert_enable)
                             || (spi_error_status_reg
                                 && spi_error_enable));
   end

   // Controller drive; pin four asserted after the window, pin three on comm_fault.
   // Pin three's window drive must not pass for a communication fault.
   always @(posedge sys_clk) begin
      if (soft_rst) begin
         drive_reg    <= 4'h0;
         diag_drv_reg <= 1'b0;
      end else if (mode_reg == `SMMC_MODE_DIAG) begin
         drive_reg    <= 4'hF;
         diag_drv_reg <= 1'b1;
      end else if (mode_reg == `SMMC_MODE_SAFE) begin
         drive_reg[3]   <= 1'b1;
         drive_reg[2]   <= (drive_reg[2] && !diag_drv_reg)
                           || comm_fault;
         drive_reg[1:0] <= 2'b00;
         diag_drv_reg   <= 1'b0;
      end else begin
         drive_reg    <= 4'h0;
         diag_drv_reg <= 1'b0;
      end
   end

   // Pin stage: mask applies during the window only, per pin function
   always @(posedge sys_clk) begin
      for (i = 0; i < 4; i = i + 1) begin
         if (soft_rst) begin
            shot_reg[i]             <= 32'h0000_0000;
            pin_out_reg[i]          <= 1'b0;
            pin_oe_n_reg[i]         <= 1'b1;
            pin_drive_readback_reg[i] <= 1'b0;
            act_d_reg[i]            <= 1'b0;
         end else begin
            pin_drive_readback_reg[i] <= drive_reg[i];
            act_d_reg[i]            <= pin_act[i];
            case (pin_cfg(pin_function_config, i))
               `SMMC_CFG_SM_HI: begin
                  pin_oe_n_reg[i] <= 1'b0;
                  pin_out_reg[i]  <= pin_act[i];
               end
               `SMMC_CFG_SM_ONESHOT: begin
                  // Fires on the rise of the unmasked assertion
                  if (pin_act[i] && !act_d_reg[i])
                     shot_reg[i] <= ONESHOT;
                  else if (shot_reg[i] != 32'h0000_0000)
                     shot_reg[i] <= shot_reg[i] - 1'b1;
                  pin_out_reg[i]  <= 1'b0;
                  pin_oe_n_reg[i] <= (shot_reg[i] == 32'h0000_0000);
               end
               default: begin
                  pin_out_reg[i]  <= 1'b0;
                  pin_oe_n_reg[i] <= 1'b1;
               end
            endcase
         end
      end
   end
endmodule

// ==== verification/smmc_chk.sv ====
// Checker for the mode controller: mode, flag and pin relations.
// Assumes a bind onto smmc_controller; one clock domain only.
`timescale 1ns/1ns
module smmc_chk (
   // Clock and resets
   input wire logic       sys_clk, reset, software_power_on_reset,
   // Watched inputs
   input wire logic       watchdog_enable, watchdog_key_valid,
   input wire logic       recovery_pin_three, cfg_write_attempt,
   input wire logic       safe_monitor_alert_enable,
   input wire logic [1:0] master_slave_select,
   // Watched outputs
   input wire logic [1:0] mode_reg,
   input wire logic       keep_alive_enable_reg, cfg_write_accept_reg,
   input wire logic       spi_error_status_reg, load_config_reg,
   input wire logic       safe_monitor_alert_status_reg, alert_n_oe_reg,
   input wire logic [3:0] pin_drive_readback_reg
);
   // Soft reset takes the same soft_rst path as reset, so it masks checks as reset does
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (reset || software_power_on_reset);
   chk_wd_off_stay: assert property (
      (mode_reg == 2'h0 && !watchdog_enable && master_slave_select[1])
      |=> mode_reg != 2'h2) else $error("entry with watchdog off");
   chk_slave_pin_only: assert property (
      (mode_reg == 2'h0 && !master_slave_select[1] && !recovery_pin_three)
      |=> mode_reg != 2'h2) else $error("slave entry without pin");
   chk_sleep_no_keep: assert property (
      (mode_reg == 2'h1)[*3] |-> !keep_alive_enable_reg)
      else $error("keep-alive running in sleep");
   chk_sleep_write_refused: assert property (
      (mode_reg == 2'h1 && cfg_write_attempt) |=> !cfg_write_accept_reg
      ##[0:1] spi_error_status_reg) else $error("sleep write not refused");
   chk_entry_alert_set: assert property (
      $rose(mode_reg == 2'h2) |-> ##[0:1] safe_monitor_alert_status_reg)
      else $error("alert status missing at entry");
   chk_alert_pin_low: assert property (
      (safe_monitor_alert_status_reg && safe_monitor_alert_enable)[*3]
      |-> !alert_n_oe_reg) else $error("alert line not pulled");
   chk_load_cfg_pulse: assert property (
      load_config_reg |-> mode_reg[1] ##1 !load_config_reg)
      else $error("config load outside safe modes");
   chk_diag_all_drive: assert property (
      (mode_reg == 2'h2)[*4] |-> pin_drive_readback_reg == 4'hF)
      else $error("diagnostic drive incomplete");
   chk_diag_key_exit: assert property (
      (mode_reg == 2'h2 && watchdog_key_valid) |-> ##[1:2] mode_reg == 2'h0)
      else $error("refresh did not end diagnostics");
   cover property ($rose(mode_reg == 2'h1));
   cover property ($rose(mode_reg == 2'h2));
   cover property ($rose(mode_reg == 2'h3));
endmodule
bind smmc_controller smmc_chk chk_i (.sys_clk, .reset,
   .software_power_on_reset, .watchdog_enable, .watchdog_key_valid,
   .recovery_pin_three, .cfg_write_attempt, .safe_monitor_alert_enable,
   .master_slave_select, .mode_reg, .keep_alive_enable_reg,
   .cfg_write_accept_reg, .spi_error_status_reg, .load_config_reg,
   .safe_monitor_alert_status_reg, .alert_n_oe_reg, .pin_drive_readback_reg);

// ==== verification/smmc_host_model.sv ====
// Host model: answers the watchdog with valid or invalid key checks.
// Assumes the bench calls key() from a falling clock edge.
`timescale 1ns/1ns
module smmc_host_model (
   // Clock
   input  wire logic sys_clk,
   // Key check outcome pulses
   output logic      watchdog_key_valid,
   output logic      watchdog_key_invalid
);
   // Quiet until the bench asks for a response
   initial begin
      watchdog_key_valid   = 1'b0;
      watchdog_key_invalid = 1'b0;
   end
   // One-cycle pulses; a long gap models a slow host, and the extra
   // idle cycle keeps two pulses from landing in one time step
   task key(input logic ok, input int n, input int gap);
      repeat (n) begin
         watchdog_key_valid   = ok;
         watchdog_key_invalid = !ok;
         @(negedge sys_clk);
         watchdog_key_valid   = 1'b0;
         watchdog_key_invalid = 1'b0;
         repeat (gap + 1) @(negedge sys_clk);
      end
   endtask
endmodule

// ==== verification/test_safe_monitor_mode_controller.sv ====
// Bench for the mode controller: levels and pulses on the falling edge.
// Assumes the controller, its checker bind and the host model.
`timescale 1ns/1ns
module test_safe_monitor_mode_controller;
   // Controller inputs
   logic        sys_clk, reset, software_power_on_reset, watchdog_enable;
   logic        sleep_enable, sleep_alert_poll_enable, poll_result_valid;
   logic        sleep_error_alert_enable, comm_fault, cfg_write_attempt;
   logic        spi_error_enable, spi_error_clear, sleep_error_clear;
   logic        safe_monitor_alert_enable, safe_monitor_alert_clear;
   logic        mask_write, recovery_pin_three;
   logic [1:0]  master_slave_select;
   logic [3:0]  watchdog_fail_debounce, alert_poll_debounce;
   logic [3:0]  watchdog_clock_divider, safe_monitor_pin_mask;
   logic [7:0]  watchdog_open_window, watchdog_closed_window;
   logic [7:0]  watchdog_time_unit;
   logic [11:0] pin_function_config;
   logic [15:0] alert_poll_packet, poll_status_mask;
   logic [23:0] sleep_notify_timer, sleep_scan_delay, gpio_recovery_delay;
   wire         watchdog_key_valid, watchdog_key_invalid;
   // Controller outputs
   wire  [1:0]  mode_reg;
   wire         cfg_write_accept_reg, keep_alive_enable_reg;
   wire         poll_request_reg, load_config_reg, alert_n_out_reg;
   wire         safe_monitor_alert_status_reg, sleep_error_alert_status_reg;
   wire         spi_error_status_reg, alert_n_oe_reg;
   wire  [3:0]  pin_drive_readback_reg, pin_out_reg, pin_oe_n_reg;
   wire  [23:0] watchdog_timeout_reg;
   // Bookkeeping
   int          err_total, n_tests, polls;
   logic        load_seen, acc_seen;

   // Short one-shot so the pulse end is reached quickly
   smmc_controller #(.ONESHOT(20)) uut (.*);
   smmc_host_model host (.sys_clk, .watchdog_key_valid, .watchdog_key_invalid);

   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   // Pulse outputs are caught here so no single cycle is missed
   always @(posedge sys_clk) begin
      if (poll_request_reg) polls++;
      if (load_config_reg) load_seen = 1'b1;
      if (cfg_write_accept_reg) acc_seen = 1'b1;
   end

   task tick(input int n);
      repeat (n) @(negedge sys_clk);
   endtask
   task chk(input string nm, input logic [31:0] s, e);
      n_tests++;
      if (s !== e) begin
         err_total++;
         $display("[FAIL] %s expected %0h seen %0h", nm, e, s);
      end
   endtask
   // Bounded wait for a mode; the compare afterwards judges it
   task wmode(input logic [1:0] m, input int n);
      repeat (n) if (mode_reg !== m) tick(1);
   endtask
   task srst;
      software_power_on_reset = 1'b1;
      // Soft reset returns the pin functions to inputs
      pin_function_config = 12'h000;
      tick(1);
      software_power_on_reset = 1'b0;
      tick(2);
   endtask
   task poll(input logic [15:0] p, input int n);
      repeat (n) begin
         alert_poll_packet = p;
         poll_result_valid = 1'b1;
         tick(1);
         poll_result_valid = 1'b0;
         tick(1);
      end
   endtask
   task give_verdict;
      $display("checks %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // Power-up state and the derived timeout: (3+5)*2<<1 = 32
   task t_defaults;
      chk("mode", mode_reg, 2'h0);
      chk("pin_oe_n", pin_oe_n_reg, 4'hF);
      chk("alert_oe", alert_n_oe_reg, 1'b1);
      chk("timeout", watchdog_timeout_reg, 24'h00_0020);
      mask_write = 1'b1;
      // Pins one to three active high, pin four one-shot low
      pin_function_config = 12'hFB6;
      tick(1);
      mask_write = 1'b0;
   endtask
   // Threshold two: the third consecutive bad key enters
   task t_wd_entry;
      host.key(0, 4, 0);
      chk("wd_off", mode_reg, 2'h0);
      watchdog_enable = 1'b1;
      host.key(1, 1, 0);
      host.key(0, 2, 0);
      tick(2);
      chk("at_thr", mode_reg, 2'h0);
      host.key(0, 1, 0);
      wmode(2'h2, 4);
      chk("diag", mode_reg, 2'h2);
      chk("sm_alert", safe_monitor_alert_status_reg, 1'b1);
      tick(4);
      chk("alert_pin", alert_n_oe_reg, 1'b0);
      chk("readback", pin_drive_readback_reg, 4'hF);
      chk("pin_idle", pin_out_reg[2:0], 3'h0);
      host.key(1, 1, 3);
      chk("exit", mode_reg, 2'h0);
      safe_monitor_alert_clear = 1'b1;
      tick(1);
      safe_monitor_alert_clear = 1'b0;
      tick(2);
      chk("alert_clr", safe_monitor_alert_status_reg, 1'b0);
   endtask
   // Window runs out: config load, pin four one-shot, pin three on fault
   task t_safe;
      gpio_recovery_delay = 24'h00_000A;
      load_seen = 1'b0;
      host.key(0, 3, 0);
      wmode(2'h3, 30);
      chk("safe", mode_reg, 2'h3);
      tick(4);
      chk("cfg_load", load_seen, 1'b1);
      chk("p4_low", {pin_oe_n_reg[3], pin_out_reg[3]}, 2'h0);
      chk("p3_quiet", pin_out_reg[2], 1'b0);
      tick(25);
      chk("p4_rel", pin_oe_n_reg[3] | pin_out_reg[3], 1'b1);
      comm_fault = 1'b1;
      tick(1);
      comm_fault = 1'b0;
      tick(4);
      chk("p3_high", {pin_oe_n_reg[2], pin_out_reg[2]}, 2'h1);
      srst;
      chk("por_mode", mode_reg, 2'h0);
      chk("por_pins", pin_oe_n_reg, 4'hF);
   endtask
   // Slave ignores its own watchdog; alert line stays off when disabled
   task t_slave;
      master_slave_select = 2'h0;
      safe_monitor_alert_enable = 1'b0;
      host.key(0, 4, 0);
      chk("slave_wd", mode_reg, 2'h0);
      recovery_pin_three = 1'b1;
      wmode(2'h2, 4);
      chk("slave_in", mode_reg, 2'h2);
      tick(3);
      chk("alert_off", alert_n_oe_reg, 1'b1);
      recovery_pin_three = 1'b0;
      srst;
      master_slave_select = 2'h2;
      safe_monitor_alert_enable = 1'b1;
   endtask
   // Sleep: refused write, polling, exits by clear, timer and poll error
   task t_sleep;
      sleep_enable = 1'b1;
      wmode(2'h1, 3);
      chk("sleep", mode_reg, 2'h1);
      tick(2);
      chk("keepalive", keep_alive_enable_reg, 1'b0);
      acc_seen = 1'b0;
      cfg_write_attempt = 1'b1;
      tick(1);
      cfg_write_attempt = 1'b0;
      tick(3);
      chk("no_accept", acc_seen, 1'b0);
      chk("spi_err", spi_error_status_reg, 1'b1);
      chk("spi_pin", alert_n_oe_reg, 1'b0);
      host.key(0, 4, 0);
      chk("no_wd", mode_reg, 2'h1);
      polls = 0;
      tick(30);
      chk("polls", polls inside {[4:7]}, 1'b1);
      sleep_enable = 1'b0;
      wmode(2'h0, 3);
      chk("slp_clr", mode_reg, 2'h0);
      sleep_notify_timer = 24'h00_001E;
      sleep_enable = 1'b1;
      wmode(2'h1, 3);
      chk("slp_in", mode_reg, 2'h1);
      wmode(2'h0, 40);
      chk("slp_timer", mode_reg, 2'h0);
      sleep_enable = 1'b0;
      sleep_notify_timer = 24'h00_0200;
      tick(1);
      sleep_enable = 1'b1;
      wmode(2'h1, 3);
      poll(16'h0001, 3);
      chk("masked", mode_reg, 2'h1);
      poll(16'h0002, 3);
      wmode(2'h0, 4);
      chk("slp_err", mode_reg, 2'h0);
      chk("slp_flag", sleep_error_alert_status_reg, 1'b1);
      sleep_enable = 1'b0;
   endtask

   initial begin
      {software_power_on_reset, watchdog_enable, sleep_enable, comm_fault,
       poll_result_valid, cfg_write_attempt, spi_error_clear, mask_write,
       sleep_error_clear, safe_monitor_alert_clear, recovery_pin_three} = '0;
      {reset, sleep_alert_poll_enable, sleep_error_alert_enable,
       spi_error_enable, safe_monitor_alert_enable} = 5'h1F;
      master_slave_select = 2'h2;
      watchdog_fail_debounce = 4'h2;
      alert_poll_debounce = 4'h1;
      watchdog_open_window = 8'h03;
      watchdog_closed_window = 8'h05;
      watchdog_time_unit = 8'h02;
      watchdog_clock_divider = 4'h1;
      sleep_notify_timer = 24'h00_0200;
      sleep_scan_delay = 24'h00_0005;
      gpio_recovery_delay = 24'h00_0028;
      alert_poll_packet = 16'h0000;
      poll_status_mask = 16'h0001;
      safe_monitor_pin_mask = 4'hF;
      pin_function_config = 12'h000;
      {err_total, n_tests, polls} = '0;
      tick(20);
      reset = 1'b0;
      tick(2);
      t_defaults;
      t_wd_entry;
      t_safe;
      t_slave;
      t_sleep;
      give_verdict;
   end
   // Hang guard: the run needs well under a thousand cycles
   initial begin
      #200000;
      err_total++;
      give_verdict;
   end
endmodule
